// *** verilog/stx_pkg.sv ***
package stx_pkg;

  // ------------------------------------------------------------
  // mode and link timing
  // ------------------------------------------------------------
  localparam logic TE_LEVEL = 1'b1;
  localparam logic [3:0] D_SLOT_FIRST = 4'h8;
  localparam logic [3:0] D_SLOT_LAST = 4'h9;
  localparam logic [3:0] BIT_CNT_MAX = 4'hf;
  localparam logic [1:0] DBITS_RESET = 2'h0;

  // ------------------------------------------------------------
  // shared pin strap window
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int STRAP_TIME_NS = 200;
  localparam logic [3:0] STRAP_CYC =
    4'((STRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // s/t line states sent
  // ------------------------------------------------------------
  localparam logic [1:0] INFO0 = 2'h0;
  localparam logic [1:0] INFO1 = 2'h1;
  localparam logic [1:0] INFO3 = 2'h3;

  // ------------------------------------------------------------
  // serial control port framing
  // ------------------------------------------------------------
  localparam int SCP_REGS = 8;
  localparam logic [4:0] SCP_CMD_BITS = 5'h08;
  localparam logic [4:0] SCP_FRAME_BITS = 5'h10;
  localparam int SCP_RD_BIT = 7;
  localparam int SCP_ADDR_HI = 6;
  localparam int SCP_ADDR_LO = 4;
  localparam logic [2:0] SCP_STATUS_IDX = 3'h0;
  localparam logic [7:0] SCP_REG_RESET = 8'h00;
  localparam logic [3:0] SCP_LAST_BIT = 4'hf;

  typedef struct packed {
    logic dcl;
    logic fsc;
    logic dat;
  } stx_link_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_SEEK,
    ACC_GRANTED
  } stx_acc_t;

endpackage

// *** verilog/stx_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module stx_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff <= '0;
      q <= '0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule // stx_sync
`default_nettype wire

// *** verilog/stx_mode_dchan.sv ***
`timescale 1ns/10ps
`default_nettype none
module stx_mode_dchan (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic terminal_network_select,
  input wire stx_pkg::stx_link_t link_pins,
  input wire logic dchan_request,
  input wire logic st_access_won,
  input wire logic st_frame_locked,
  input wire logic st_info2_seen,
  input wire logic activation_request,
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe_n,
  output logic dchan_grant,
  output logic nt_mode,
  output logic adaptive_timing,
  output logic [1:0] st_dchan_bits,
  output logic st_dchan_valid,
  output logic [1:0] st_tx_info,
  input wire logic scp_clk,
  input wire logic scp_en_n,
  input wire logic scp_din,
  output logic scp_dout
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [12:0] raw_pins;
  logic [12:0] sy_pins;
  stx_pkg::stx_link_t link_s;
  logic tns_s, dreq_s, won_s, lock_s, info2_s, act_s, shin_s;
  logic sclk_s, sen_n_s, sdin_s;

  assign raw_pins = {terminal_network_select, link_pins, dchan_request, st_access_won,
                     st_frame_locked, st_info2_seen, activation_request, shared_pin_in,
                     scp_clk, scp_en_n, scp_din};

  stx_sync #(.W(13)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(raw_pins),
    .q(sy_pins)
  );

  assign {tns_s, link_s, dreq_s, won_s, lock_s, info2_s, act_s, shin_s,
          sclk_s, sen_n_s, sdin_s} = sy_pins;

  // ------------------------------------------------------------
  // mode select
  // ------------------------------------------------------------
  wire te_mode = (tns_s == stx_pkg::TE_LEVEL);

  // ------------------------------------------------------------
  // time-slot link, slave to inbound clock and sync
  // ------------------------------------------------------------
  logic dcl_d_ff;
  logic [3:0] bit_cnt_ff;
  wire dcl_fall = dcl_d_ff & ~link_s.dcl;
  wire [3:0] nxt_bit_cnt = link_s.fsc ? 4'h0 :
                           (bit_cnt_ff == stx_pkg::BIT_CNT_MAX) ? bit_cnt_ff :
                           bit_cnt_ff + 4'h1;
  wire slot_bit = dcl_fall && (bit_cnt_ff >= stx_pkg::D_SLOT_FIRST)
                  && (bit_cnt_ff <= stx_pkg::D_SLOT_LAST);
  wire slot_first = slot_bit && (bit_cnt_ff == stx_pkg::D_SLOT_FIRST);
  wire slot_last = slot_bit && (bit_cnt_ff == stx_pkg::D_SLOT_LAST);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dcl_d_ff <= 1'b0;
      bit_cnt_ff <= stx_pkg::BIT_CNT_MAX;
    end
    else
    begin
      dcl_d_ff <= link_s.dcl;
      if (dcl_fall)
        bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // ------------------------------------------------------------
  // d-channel access
  // ------------------------------------------------------------
  stx_pkg::stx_acc_t acc_ff, nxt_acc;

  always_comb
  begin
    nxt_acc = acc_ff;
    unique case (acc_ff)
      stx_pkg::ACC_IDLE:
        if (te_mode && dreq_s)
          nxt_acc = stx_pkg::ACC_SEEK;
      stx_pkg::ACC_SEEK:
        if (!te_mode || !dreq_s)
          nxt_acc = stx_pkg::ACC_IDLE;
        else if (won_s)
          nxt_acc = stx_pkg::ACC_GRANTED;
      stx_pkg::ACC_GRANTED:
        if (!te_mode || !dreq_s)
          nxt_acc = stx_pkg::ACC_IDLE;
    endcase
  end

  wire nxt_grant = (nxt_acc == stx_pkg::ACC_GRANTED);

  // a slot counts only when the grant stood at its first bit
  logic cap_ff;
  logic [1:0] dbits_ff;
  wire nxt_cap = slot_first ? dchan_grant : (cap_ff & dchan_grant);
  wire [1:0] nxt_dbits = {dbits_ff[0], link_s.dat};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_ff <= stx_pkg::ACC_IDLE;
      dchan_grant <= 1'b0;
      cap_ff <= 1'b0;
      dbits_ff <= stx_pkg::DBITS_RESET;
      st_dchan_bits <= stx_pkg::DBITS_RESET;
      st_dchan_valid <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      dchan_grant <= nxt_grant;
      if (slot_bit)
      begin
        cap_ff <= nxt_cap;
        dbits_ff <= nxt_dbits;
      end
      st_dchan_valid <= slot_last & nxt_cap;
      if (slot_last & nxt_cap)
        st_dchan_bits <= nxt_dbits;
    end
  end

  // ------------------------------------------------------------
  // shared pin: strap read, then frame sync indication in network mode only
  // ------------------------------------------------------------
  logic [3:0] strap_cnt_ff;
  logic strap_done_ff;
  wire strap_take = !strap_done_ff && (strap_cnt_ff == stx_pkg::STRAP_CYC);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_cnt_ff <= 4'h0;
      strap_done_ff <= 1'b0;
      adaptive_timing <= 1'b0;
      shared_pin_out <= 1'b0;
      shared_pin_oe_n <= 1'b1;
      nt_mode <= 1'b0;
    end
    else
    begin
      nt_mode <= !te_mode;
      if (!strap_done_ff)
        strap_cnt_ff <= strap_cnt_ff + 4'h1;
      if (strap_take)
      begin
        strap_done_ff <= 1'b1;
        adaptive_timing <= shin_s;
      end
      shared_pin_oe_n <= !(strap_done_ff && !te_mode);
      shared_pin_out <= lock_s && !te_mode;
    end
  end

  // ------------------------------------------------------------
  // activation line state
  // ------------------------------------------------------------
  wire [1:0] nxt_info = (te_mode || !act_s) ? stx_pkg::INFO0 :
                        (info2_s || st_tx_info == stx_pkg::INFO3) ? stx_pkg::INFO3 :
                        stx_pkg::INFO1;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_tx_info <= stx_pkg::INFO0;
    else
      st_tx_info <= nxt_info;
  end

  // ------------------------------------------------------------
  // serial control port
  // ------------------------------------------------------------
  logic [7:0] regs_ff [stx_pkg::SCP_REGS];
  logic sclk_d_ff;
  logic [4:0] scnt_ff;
  logic [7:0] cmd_ff;
  logic [6:0] wsh_ff;
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire [2:0] s_addr = cmd_ff[stx_pkg::SCP_ADDR_HI:stx_pkg::SCP_ADDR_LO];
  wire s_read = cmd_ff[stx_pkg::SCP_RD_BIT];
  wire [7:0] status_word = {3'h0, te_mode, adaptive_timing, shared_pin_out,
                            dchan_grant, strap_done_ff};
  wire [7:0] rd_word = (s_addr == stx_pkg::SCP_STATUS_IDX) ? status_word : regs_ff[s_addr];
  wire in_data = (scnt_ff >= stx_pkg::SCP_CMD_BITS) && (scnt_ff < stx_pkg::SCP_FRAME_BITS);
  wire [3:0] rd_pos = stx_pkg::SCP_LAST_BIT - scnt_ff[3:0];
  wire s_commit = sclk_rise && !sen_n_s && !s_read
                  && (scnt_ff == stx_pkg::SCP_FRAME_BITS - 5'h01)
                  && (s_addr != stx_pkg::SCP_STATUS_IDX);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_d_ff <= 1'b0;
      scnt_ff <= 5'h00;
      cmd_ff <= 8'h00;
      wsh_ff <= 7'h00;
      scp_dout <= 1'b0;
      for (int i = 0; i < stx_pkg::SCP_REGS; i++)
        regs_ff[i] <= stx_pkg::SCP_REG_RESET;
    end
    else
    begin
      sclk_d_ff <= sclk_s;
      if (sen_n_s)
        scnt_ff <= 5'h00;
      else if (sclk_rise && scnt_ff < stx_pkg::SCP_FRAME_BITS)
      begin
        scnt_ff <= scnt_ff + 5'h01;
        if (scnt_ff < stx_pkg::SCP_CMD_BITS)
          cmd_ff <= {cmd_ff[6:0], sdin_s};
        else
          wsh_ff <= {wsh_ff[5:0], sdin_s};
      end
      if (s_commit)
        regs_ff[s_addr] <= {wsh_ff, sdin_s};
      if (sclk_fall && !sen_n_s && in_data && s_read)
        scp_dout <= rd_word[rd_pos[2:0]];
      else if (sen_n_s)
        scp_dout <= 1'b0;
    end
  end

endmodule // stx_mode_dchan
`default_nettype wire

// *** test/stx_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module stx_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic terminal_network_select,
  input wire logic dchan_request,
  input wire logic st_access_won,
  input wire logic st_frame_locked,
  input wire logic activation_request,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe_n,
  input wire logic dchan_grant,
  input wire logic nt_mode,
  input wire logic adaptive_timing,
  input wire logic [1:0] st_tx_info
);
  // ----
  // port relations
  // ----
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_mode_network: assert property (!terminal_network_select [*5] |=> nt_mode)
    else $error("nt_mode low");
  a_grant_cause: assert property ($rose(dchan_grant) |->
    $past(st_access_won, 3) && $past(terminal_network_select, 3)) else $error("grant early");
  a_grant_release: assert property (!dchan_request [*5] |=> !dchan_grant)
    else $error("grant held");
  a_grant_nt_off: assert property (!terminal_network_select [*5] |=> !dchan_grant)
    else $error("grant in nt");
  a_pin_te_off: assert property (terminal_network_select [*5] |=> shared_pin_oe_n)
    else $error("pin driven in te");
  a_ind_unlocked: assert property (!st_frame_locked [*5] |=> !shared_pin_out)
    else $error("indicator high");
  a_strap_kept: assert property (!shared_pin_oe_n |-> $stable(adaptive_timing))
    else $error("strap changed");
  a_info_idle: assert property (!activation_request [*5] |=>
    st_tx_info == stx_pkg::INFO0) else $error("not idle");
endmodule // stx_chk
bind stx_mode_dchan stx_chk chk (.clk(clk), .reset_n(reset_n),
  .terminal_network_select(terminal_network_select), .dchan_request(dchan_request),
  .st_access_won(st_access_won), .st_frame_locked(st_frame_locked),
  .activation_request(activation_request), .shared_pin_out(shared_pin_out),
  .shared_pin_oe_n(shared_pin_oe_n), .dchan_grant(dchan_grant), .nt_mode(nt_mode),
  .adaptive_timing(adaptive_timing), .st_tx_info(st_tx_info));
`default_nettype wire

// *** test/stx_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
module stx_peer (
  input wire logic want,
  input wire logic [1:0] dbits,
  input wire logic dchan_grant,
  output logic dchan_request,
  output var stx_pkg::stx_link_t link
);
  // ----
  // d-channel controller and link timing
  // ----
  assign dchan_request = want;
  // one process owns the link; idle data keeps changing, link clock stands still
  initial
  begin
    link = 3'b100;
    forever
    begin
      if (want && dchan_grant)
      begin
        // the fall with fsc high restarts the count; the d slot is falls 9 and 10 after it
        for (int i = 0; i < 11; i++)
        begin
          link.fsc = (i == 0);
          link.dat = i == 9 ? dbits[1] : i == 10 ? dbits[0] : ~link.dat;
          #80 link.dcl = 1'b0;
          #80 link.dcl = 1'b1;
        end
        link.fsc = 1'b0;
        while (dchan_grant)
          #80 link.dat = ~link.dat;
      end
      else
        #80 link.dat = ~link.dat;
    end
  end
endmodule // stx_peer
`default_nettype wire

// *** test/stx_mode_dchan_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module stx_mode_dchan_tb;
  typedef struct packed {
    logic sel, act, i2, lock, req;
    logic [1:0] info;
    logic pout;
  } stx_row_t;
  // ----
  // rows: sel act i2 lock req | info pout
  // ----
  localparam stx_row_t ROWS [5] = '{8'h19, 8'h4a, 8'h77, 8'hd0, 8'h80};
  logic clk, reset_n, sel, won, lock, i2, act, strap, want, req, pout, oe_n, grant, ntm;
  logic adap, valid;
  logic scp_clk, scp_en_n, scp_din, scp_dout;
  logic [7:0] rdat;
  logic [1:0] dbits, bits, info;
  stx_pkg::stx_link_t link;
  int error_cnt, cmp_count, n;
  wire logic pin = oe_n ? strap : pout;
  stx_mode_dchan dut (.clk(clk), .reset_n(reset_n), .terminal_network_select(sel),
    .link_pins(link), .dchan_request(req), .st_access_won(won), .st_frame_locked(lock),
    .st_info2_seen(i2), .activation_request(act), .shared_pin_in(pin),
    .shared_pin_out(pout), .shared_pin_oe_n(oe_n), .dchan_grant(grant), .nt_mode(ntm),
    .adaptive_timing(adap), .st_dchan_bits(bits), .st_dchan_valid(valid),
    .st_tx_info(info), .scp_clk(scp_clk), .scp_en_n(scp_en_n), .scp_din(scp_din),
    .scp_dout(scp_dout));
  stx_peer peer (.want(want), .dbits(dbits), .dchan_grant(grant), .dchan_request(req),
    .link(link));
  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // one control port frame: 8 command bits then 8 data bits, msb first
  task automatic scp_xfer(input logic [15:0] frame, output logic [7:0] rd);
    rd = 8'h00;
    scp_en_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int b = 15; b >= 0; b--)
    begin
      scp_din = frame[b];
      repeat (4) @(negedge clk);
      scp_clk = 1'b1;
      repeat (4) @(negedge clk);
      if (b < 8)
        rd[b] = scp_dout;
      scp_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    scp_en_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {reset_n, sel, won, lock, i2, act, want, dbits} = '0;
    {scp_clk, scp_din, scp_en_n} = 3'b001;
    strap = 1'b1;
    repeat (16) @(negedge clk);
    {reset_n, won} = 2'b11;
    repeat (14) @(negedge clk);
    chk("adaptive_timing", 2'b01, {1'b0, adap});
    foreach (ROWS[r])
    begin
      {sel, act, i2, lock, want} = ROWS[r][7:3];
      repeat (8) @(negedge clk);
      chk("st_tx_info", ROWS[r].info, info);
      chk("shared_pin_out", {1'b0, ROWS[r].pout}, {1'b0, pout});
      chk("nt_mode", {1'b0, ~ROWS[r].sel}, {1'b0, ntm});
      chk("shared_pin_oe_n", {1'b0, ROWS[r].sel}, {1'b0, oe_n});
      chk("dchan_grant", 2'b00, {1'b0, grant});
    end
    // two d slot transfers with the grant released between them, both bit orders
    for (int j = 2; j > 0; j--)
    begin
      {want, dbits} = {1'b1, 2'(j)};
      for (n = 0; valid !== 1'b1; n++)
      begin
        if (n == 400)
        begin
          error_cnt++;
          final_report();
        end
        @(negedge clk);
      end
      chk("st_dchan_bits", dbits, bits);
      chk("dchan_grant", 2'b01, {1'b0, grant});
      want = 1'b0;
      repeat (5) @(negedge clk);
      chk("dchan_grant", 2'b00, {1'b0, grant});
    end
    // control port: status is read only, plain registers keep writes
    scp_xfer(16'h00ff, rdat);
    scp_xfer(16'h8000, rdat);
    chk8("status", 8'h19, rdat);
    scp_xfer(16'h305a, rdat);
    scp_xfer(16'hb000, rdat);
    chk8("reg3", 8'h5a, rdat);
    // mid-run reset in network mode with the fixed-timing strap
    {reset_n, strap, sel} = 3'b000;
    @(negedge clk);
    reset_n = 1'b1;
    repeat (14) @(negedge clk);
    chk("adaptive_timing", 2'b00, {1'b0, adap});
    chk("shared_pin_oe_n", 2'b00, {1'b0, oe_n});
    scp_xfer(16'hb000, rdat);
    chk8("reg3", 8'h00, rdat);
    scp_xfer(16'h8000, rdat);
    chk8("status", 8'h01, rdat);
    final_report();
  end
endmodule // stx_mode_dchan_tb
`default_nettype wire
